/* File: hw/cfs_top.sv */
// CAN receive queue, master status and transmit status with APB slave
//
// The register offsets and register access over APB were decided locally.
module cfs_top
   import cfs_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_clock,
   input  wire logic                 i_rst_b,
   // APB slave
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [7:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic [31:0]               o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   // Bus pin and bit timing
   input  wire logic                 i_can_rx,
   input  wire logic                 i_bit_tick,
   // Protocol engine
   input  wire cfs_rx_chk_t          i_rx_chk,
   input  wire cfs_rx_msg_t          i_rx_msg,
   input  wire logic                 i_sof_detect,
   input  wire logic                 i_role_rx,
   input  wire logic                 i_role_tx,
   input  wire logic [CFS_ERR_W-1:0] i_err_set,
   // Transmit mailbox logic
   input  wire logic [CFS_NMB-1:0]   i_tx_req,
   input  wire logic [CFS_NMB-1:0]   i_tx_done,
   input  wire logic [CFS_NMB-1:0]   i_tx_ok,
   // Mode and interrupt
   output logic                      o_init_mode,
   output logic                      o_sleep_mode,
   output logic                      o_irq
);
   cfs_mode_t              mode_reg;
   cfs_mode_t              mode_next;
   cfs_rx_msg_t            head;
   logic                   init_request_reg;
   logic                   sleep_request_reg;
   logic                   auto_wake_reg;
   logic                   init_ack_reg;
   logic                   wake_reg;
   logic                   err_reg;
   logic                   role_rx_reg;
   logic                   role_tx_reg;
   logic [CFS_NMB-1:0]     rqcp_reg;
   logic [CFS_NMB-1:0]     txok_reg;
   logic [CFS_IRQ_W-1:0]   ier_reg;
   logic [CFS_ERR_W-1:0]   eier_reg;
   logic [CFS_IRQ_W-1:0]   istat_reg;
   logic [CFS_IRQ_W-1:0]   ievt;
   logic [31:0]            prdata_reg;
   logic [31:0]            rd_next;
   logic                   pslverr_reg;
   logic                   err_next;
   logic                   rx_meta_reg;
   logic                   rx_sync_reg;
   logic [3:0]             rec_cnt_reg;
   logic                   sync_done;
   logic                   full_d_reg;
   logic                   setup;
   logic                   wr_en;
   logic [7:0]             wdata;
   logic [7:0]             mstat;
   logic [7:0]             tstat;
   logic [7:0]             ms_clr;
   logic [7:0]             ts_clr;
   logic                   push;
   logic                   release_mb;
   logic [1:0]             fifo_count;
   logic                   fifo_full;
   logic                   fifo_ovr;
   logic                   wake_set;
   logic                   err_set;

   // APB decode
   assign setup   = i_psel && !i_penable;
   assign wr_en   = i_psel && i_penable && i_pwrite;
   assign wdata   = i_pwdata[7:0];
   assign ms_clr  = (wr_en && i_paddr == CFS_OFS_MSTAT) ? wdata : 8'h00;
   assign ts_clr  = (wr_en && i_paddr == CFS_OFS_TSTAT) ? wdata : 8'h00;
   assign release_mb = wr_en && (i_paddr == CFS_OFS_FIFO) &&
                       i_pwdata[CFS_FC_RELEASE];

   // Pin synchroniser
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_meta_reg <= 1'h1;
         rx_sync_reg <= 1'h1;
      end else begin
         rx_meta_reg <= i_can_rx;
         rx_sync_reg <= rx_meta_reg;
      end
   end

   // Consecutive recessive bit counter while synchronising
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rec_cnt_reg <= 4'h0;
      end else if (mode_reg != MODE_SYNC) begin
         rec_cnt_reg <= 4'h0;
      end else if (i_bit_tick) begin
         if (!rx_sync_reg) begin
            rec_cnt_reg <= 4'h0;
         end else if (!sync_done) begin
            rec_cnt_reg <= rec_cnt_reg + 4'h1;
         end
      end
   end
   assign sync_done = (rec_cnt_reg == CFS_SYNC_BITS);

   // Master control register
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         init_request_reg  <= CFS_INIT_RST;
         sleep_request_reg <= CFS_SLEEP_RST;
         auto_wake_reg     <= CFS_AWAKE_RST;
      end else begin
         if (wr_en && i_paddr == CFS_OFS_MCTRL) begin
            init_request_reg  <= i_pwdata[CFS_MC_INIT];
            sleep_request_reg <= i_pwdata[CFS_MC_SLEEP];
            auto_wake_reg     <= i_pwdata[CFS_MC_AWAKE];
         end
         if (wake_set && auto_wake_reg) begin
            sleep_request_reg <= 1'h0;
         end
      end
   end

   // Operating mode
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_SLEEP: begin
            if (!sleep_request_reg) begin
               mode_next = init_request_reg ? MODE_INIT : MODE_SYNC;
            end
         end
         MODE_INIT: begin
            if (sleep_request_reg) begin
               mode_next = MODE_SLEEP;
            end else if (!init_request_reg) begin
               mode_next = MODE_SYNC;
            end
         end
         MODE_SYNC: begin
            if (init_request_reg) begin
               mode_next = MODE_INIT;
            end else if (sleep_request_reg) begin
               mode_next = MODE_SLEEP;
            end else if (sync_done) begin
               mode_next = MODE_NORMAL;
            end
         end
         MODE_NORMAL: begin
            if (init_request_reg) begin
               mode_next = MODE_INIT;
            end else if (sleep_request_reg) begin
               mode_next = MODE_SLEEP;
            end
         end
         default: begin
            mode_next = MODE_SLEEP;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mode_reg <= MODE_SLEEP;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Init acknowledge held through synchronisation
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         init_ack_reg <= CFS_MSTAT_RST[CFS_MS_INIT_ACK];
      end else if (mode_next == MODE_INIT) begin
         init_ack_reg <= 1'h1;
      end else if (mode_next != MODE_SYNC) begin
         init_ack_reg <= 1'h0;
      end
   end

   // Role, wake-up and error flags
   assign wake_set = i_sof_detect && (mode_reg == MODE_SLEEP);
   assign err_set  = |(i_err_set & eier_reg);

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wake_reg    <= CFS_MSTAT_RST[CFS_MS_WAKE];
         err_reg     <= CFS_MSTAT_RST[CFS_MS_ERR];
         role_rx_reg <= CFS_MSTAT_RST[CFS_MS_ROLE_RX];
         role_tx_reg <= CFS_MSTAT_RST[CFS_MS_ROLE_TX];
      end else begin
         role_rx_reg <= i_role_rx;
         role_tx_reg <= i_role_tx;
         if (wake_set) begin
            wake_reg <= 1'h1;
         end else if (ms_clr[CFS_MS_WAKE]) begin
            wake_reg <= 1'h0;
         end
         if (err_set) begin
            err_reg <= 1'h1;
         end else if (ms_clr[CFS_MS_ERR]) begin
            err_reg <= 1'h0;
         end
      end
   end

   // Transmit completion and success flags per mailbox
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rqcp_reg <= CFS_TSTAT_RST[CFS_TS_RQ0 +: CFS_NMB];
         txok_reg <= CFS_TSTAT_RST[CFS_TS_OK0 +: CFS_NMB];
      end else begin
         for (int m = 0; m < CFS_NMB; m++) begin
            if (i_tx_done[m]) begin
               rqcp_reg[m] <= 1'h1;
            end else if (ts_clr[CFS_TS_RQ0 + m]) begin
               rqcp_reg[m] <= 1'h0;
            end
            if (i_tx_done[m] && i_tx_ok[m]) begin
               txok_reg[m] <= 1'h1;
            end else if (i_tx_req[m] || ts_clr[CFS_TS_RQ0 + m]) begin
               txok_reg[m] <= 1'h0;
            end
         end
      end
   end

   // Status register images
   assign mstat = {2'h0, role_rx_reg, role_tx_reg, wake_reg, err_reg,
                   (mode_reg == MODE_SLEEP), init_ack_reg};
   assign tstat = {2'h0, txok_reg, 2'h0, rqcp_reg};

   // Receive queue
   assign push = i_rx_chk.frame_end && i_rx_chk.no_error &&
                 i_rx_chk.filter_pass && (mode_reg == MODE_NORMAL);

   cfs_rx_fifo u_fifo (
      .i_clock   (i_clock),
      .i_rst_b   (i_rst_b),
      .i_push    (push),
      .i_msg     (i_rx_msg),
      .i_release (release_mb),
      .o_head    (head),
      .o_count   (fifo_count),
      .o_full    (fifo_full),
      .o_overrun (fifo_ovr)
   );

   // Interrupt enable registers
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ier_reg  <= CFS_IRQ_RST;
         eier_reg <= '0;
      end else begin
         if (wr_en && i_paddr == CFS_OFS_IER) begin
            ier_reg <= i_pwdata[CFS_IRQ_W-1:0];
         end
         if (wr_en && i_paddr == CFS_OFS_EIER) begin
            eier_reg <= i_pwdata[CFS_ERR_W-1:0];
         end
      end
   end

   // Sticky interrupt status
   always_comb begin
      ievt = '0;
      ievt[CFS_IRQ_TX]   = |i_tx_done;
      ievt[CFS_IRQ_MSG]  = push;
      ievt[CFS_IRQ_FULL] = fifo_full && !full_d_reg;
      ievt[CFS_IRQ_OVR]  = fifo_ovr;
      ievt[CFS_IRQ_ERR]  = err_set;
      ievt[CFS_IRQ_WAKE] = wake_set;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         istat_reg  <= CFS_IRQ_RST;
         full_d_reg <= 1'h0;
      end else begin
         full_d_reg <= fifo_full;
         if (wr_en && i_paddr == CFS_OFS_ISTAT) begin
            istat_reg <= ievt | (istat_reg & ~i_pwdata[CFS_IRQ_W-1:0]);
         end else begin
            istat_reg <= istat_reg | ievt;
         end
      end
   end
   assign o_irq = |(istat_reg & ier_reg);

   // Read mux sampled in the setup cycle
   always_comb begin
      rd_next  = 32'h0000_0000;
      err_next = 1'h0;
      case (i_paddr)
         CFS_OFS_MCTRL: begin
            rd_next[CFS_MC_INIT]  = init_request_reg;
            rd_next[CFS_MC_SLEEP] = sleep_request_reg;
            rd_next[CFS_MC_AWAKE] = auto_wake_reg;
         end
         CFS_OFS_MSTAT:  rd_next[7:0] = mstat;
         CFS_OFS_TSTAT:  rd_next[7:0] = tstat;
         CFS_OFS_IER:    rd_next[CFS_IRQ_W-1:0] = ier_reg;
         CFS_OFS_EIER:   rd_next[CFS_ERR_W-1:0] = eier_reg;
         CFS_OFS_ISTAT:  rd_next[CFS_IRQ_W-1:0] = istat_reg;
         CFS_OFS_FIFO: begin
            rd_next[1:0]         = fifo_count;
            rd_next[CFS_FC_FULL] = fifo_full;
         end
         CFS_OFS_MB_ID:  rd_next = {head.ide, head.rtr, 1'h0, head.id};
         CFS_OFS_MB_DLC: rd_next[3:0] = head.dlc;
         CFS_OFS_MB_DLO: rd_next = head.data[31:0];
         CFS_OFS_MB_DHI: rd_next = head.data[63:32];
         default:        err_next = 1'h1;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'h0;
      end else if (setup) begin
         prdata_reg  <= rd_next;
         pslverr_reg <= err_next;
      end
   end

   assign o_prdata     = prdata_reg;
   assign o_pslverr    = pslverr_reg && i_psel && i_penable;
   assign o_pready     = 1'h1;
   assign o_init_mode  = (mode_reg == MODE_INIT);
   assign o_sleep_mode = (mode_reg == MODE_SLEEP);

   // Checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence s_sleeping_released;
      (mode_reg == MODE_SLEEP) && !sleep_request_reg;
   endsequence
   sequence s_init_withdrawn;
      init_ack_reg && !init_request_reg && !sleep_request_reg;
   endsequence

   AST_BAD_FRAME_DROPPED: assert property (
      (i_rx_chk.frame_end && !i_rx_chk.no_error && !release_mb)
      |=> fifo_count == $past(fifo_count))
      else $error("errored frame entered the receive queue");
   AST_QUEUE_BOUND: assert property (
      (push && fifo_full && !release_mb)
      |=> fifo_count == CFS_FIFO_FULL && fifo_ovr)
      else $error("receive queue grew beyond three slots");
   AST_RELEASE_POPS: assert property (
      (release_mb && fifo_count != 2'h0 && !push)
      |=> fifo_count == $past(fifo_count) - 2'h1)
      else $error("release did not retire the output mailbox");
   AST_STATUS_RESERVED: assert property (
      (setup && (i_paddr == CFS_OFS_MSTAT || i_paddr == CFS_OFS_TSTAT))
      |=> o_prdata[7:6] == 2'h0)
      else $error("reserved status bits not zero");
   AST_ROLE_FOLLOWS: assert property (
      ##1 mstat[CFS_MS_ROLE_RX] == $past(i_role_rx))
      else $error("receiver role flag stale");
   AST_WAKE_SET: assert property (
      (i_sof_detect && mode_reg == MODE_SLEEP) |=> wake_reg)
      else $error("wake-up flag missed a start of frame in sleep");
   AST_ERR_SET: assert property (
      (|(i_err_set & eier_reg)) |=> err_reg ##1
      (err_reg || $past(ms_clr[CFS_MS_ERR])))
      else $error("error flag not set by enabled error event");
   AST_SLEEP_LEFT: assert property (
      s_sleeping_released |=> !mstat[CFS_MS_SLEEP_ACK])
      else $error("sleep acknowledge held after sleep left");
   AST_INIT_ACK_SET: assert property (
      (init_request_reg && !sleep_request_reg && mode_reg != MODE_SLEEP)
      |=> init_ack_reg)
      else $error("init acknowledge missing in init mode");
   AST_INIT_ACK_HOLD: assert property (
      (s_init_withdrawn ##1 (mode_reg == MODE_SYNC && !sync_done))
      |-> init_ack_reg)
      else $error("init acknowledge cleared before 11 recessive bits");
   AST_TXOK_SET: assert property (
      (i_tx_done[1] && i_tx_ok[1]) |=> txok_reg[1] && rqcp_reg[1])
      else $error("mailbox 1 success flag not set");
   AST_TXOK_CLEAR: assert property (
      (i_tx_req[1] && !i_tx_done[1]) |=> !txok_reg[1])
      else $error("mailbox 1 success flag kept over new request");
endmodule

/* File: pkg/cfs_pkg.sv */
// Constants and types of the CAN receive queue and status flag block
package cfs_pkg;
   // Widths and depths
   localparam int         CFS_ERR_W       = 8;
   localparam int         CFS_IRQ_W       = 6;
   localparam int         CFS_NMB         = 2;
   localparam int         CFS_FIFO_DEPTH  = 3;
   localparam logic [1:0] CFS_FIFO_LAST   = 2'h2;
   localparam logic [1:0] CFS_FIFO_FULL   = 2'h3;
   localparam logic [3:0] CFS_SYNC_BITS   = 4'hB;
   // Register offsets
   localparam logic [7:0] CFS_OFS_MCTRL   = 8'h00;
   localparam logic [7:0] CFS_OFS_MSTAT   = 8'h04;
   localparam logic [7:0] CFS_OFS_TSTAT   = 8'h08;
   localparam logic [7:0] CFS_OFS_IER     = 8'h0C;
   localparam logic [7:0] CFS_OFS_EIER    = 8'h10;
   localparam logic [7:0] CFS_OFS_ISTAT   = 8'h14;
   localparam logic [7:0] CFS_OFS_FIFO    = 8'h18;
   localparam logic [7:0] CFS_OFS_MB_ID   = 8'h1C;
   localparam logic [7:0] CFS_OFS_MB_DLC  = 8'h20;
   localparam logic [7:0] CFS_OFS_MB_DLO  = 8'h24;
   localparam logic [7:0] CFS_OFS_MB_DHI  = 8'h28;
   // Master control fields
   localparam int         CFS_MC_INIT     = 0;
   localparam int         CFS_MC_SLEEP    = 1;
   localparam int         CFS_MC_AWAKE    = 5;
   localparam logic       CFS_INIT_RST    = 1'h0;
   localparam logic       CFS_SLEEP_RST   = 1'h1;
   localparam logic       CFS_AWAKE_RST   = 1'h0;
   // Master status fields
   localparam int         CFS_MS_ROLE_RX  = 5;
   localparam int         CFS_MS_ROLE_TX  = 4;
   localparam int         CFS_MS_WAKE     = 3;
   localparam int         CFS_MS_ERR      = 2;
   localparam int         CFS_MS_SLEEP_ACK     = 1;
   localparam int         CFS_MS_INIT_ACK     = 0;
   localparam logic [7:0] CFS_MSTAT_RST   = 8'h02;
   // Transmit status fields
   localparam int         CFS_TS_OK0      = 4;
   localparam int         CFS_TS_RQ0      = 0;
   localparam logic [7:0] CFS_TSTAT_RST   = 8'h00;
   // Interrupt status and enable fields
   localparam int         CFS_IRQ_TX      = 0;
   localparam int         CFS_IRQ_MSG     = 1;
   localparam int         CFS_IRQ_FULL    = 2;
   localparam int         CFS_IRQ_OVR     = 3;
   localparam int         CFS_IRQ_ERR     = 4;
   localparam int         CFS_IRQ_WAKE    = 5;
   localparam logic [5:0] CFS_IRQ_RST     = 6'h00;
   // Queue control fields
   localparam int         CFS_FC_FULL     = 3;
   localparam int         CFS_FC_RELEASE  = 5;
   typedef struct packed {
      logic [28:0] id;
      logic        ide;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;
   } cfs_rx_msg_t;
   typedef struct packed {
      logic frame_end;
      logic no_error;
      logic filter_pass;
   } cfs_rx_chk_t;
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_INIT,
      MODE_SYNC,
      MODE_NORMAL
   } cfs_mode_t;
endpackage

/* File: hw/cfs_rx_fifo.sv */
// Three-slot receive queue with an output mailbox at its head
module cfs_rx_fifo
   import cfs_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   // Filling side
   input  wire logic        i_push,
   input  wire cfs_rx_msg_t i_msg,
   // Draining side
   input  wire logic        i_release,
   output cfs_rx_msg_t      o_head,
   output logic [1:0]       o_count,
   output logic             o_full,
   output logic             o_overrun
);
   cfs_rx_msg_t slot_reg [CFS_FIFO_DEPTH];
   logic [1:0]  rd_reg;
   logic [1:0]  wr_reg;
   logic [1:0]  count_reg;
   logic        ovr_reg;
   logic        do_pop;
   logic        do_push;

   function automatic logic [1:0] bump(input logic [1:0] p);
      bump = (p == CFS_FIFO_LAST) ? 2'h0 : p + 2'h1;
   endfunction

   // Queue filled by hardware, drained by software release
   assign do_pop  = i_release && (count_reg != 2'h0);
   assign do_push = i_push && ((count_reg != CFS_FIFO_FULL) || do_pop);

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_reg    <= 2'h0;
         wr_reg    <= 2'h0;
         count_reg <= 2'h0;
      end else begin
         if (do_pop) begin
            rd_reg <= bump(rd_reg);
         end
         if (do_push) begin
            wr_reg <= bump(wr_reg);
         end
         if (do_push && !do_pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (do_pop && !do_push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end

   // Slot storage
   always_ff @(posedge i_clock) begin
      if (do_push) begin
         slot_reg[wr_reg] <= i_msg;
      end
   end

   // Overrun pulse when a valid frame finds no room
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovr_reg <= 1'h0;
      end else begin
         ovr_reg <= i_push && !do_push;
      end
   end

   // Oldest message shown to software
   assign o_head    = slot_reg[rd_reg];
   assign o_count   = count_reg;
   assign o_full    = (count_reg == CFS_FIFO_FULL);
   assign o_overrun = ovr_reg;
endmodule

/* File: sim/cfs_node_model.sv */
// Model of the protocol side: bus pin, bit ticks and received frames
module cfs_node_model
   import cfs_pkg::*;
(
   // Clock
   input  wire logic  i_clock,
   // Toward the block
   output logic        o_can_rx,
   output logic        o_bit_tick,
   output cfs_rx_chk_t o_rx_chk,
   output cfs_rx_msg_t o_rx_msg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] tick_cnt = 2'h0;
   initial begin
      o_can_rx = 1'b1;
      o_rx_chk = '0;
      o_rx_msg = '0;
   end
   // One bit every four clocks, bus idle recessive
   always @(posedge i_clock) begin
      tick_cnt <= tick_cnt + 2'h1;
   end
   assign o_bit_tick = (tick_cnt == 2'h0);
   // Dominant level held for a number of clocks
   task automatic dominant(input int n);
      @(posedge i_clock);
      o_can_rx <= 1'b0;
      repeat (n) @(posedge i_clock);
      o_can_rx <= 1'b1;
   endtask
   // One frame end pulse; message scrambled once it is over
   task automatic send(input logic [63:0] d, input logic ok,
                       input logic hit);
      @(posedge i_clock);
      o_rx_msg <= {29'h0000_0123, 1'b0, 1'b0, 4'h8, d};
      o_rx_chk <= '{frame_end: 1'b1, no_error: ok, filter_pass: hit};
      @(posedge i_clock);
      o_rx_chk <= '0;
      o_rx_msg <= ~o_rx_msg;
   endtask
endmodule

/* File: sim/cfs_top_tb.sv */
// Self-checking bench of the receive queue and status flags
module cfs_top_tb;
   import cfs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clock = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, last_err;
   logic [7:0]  paddr, err_set;
   logic [31:0] pwdata, prdata;
   logic        can_rx, bit_tick, sof, role_rx, role_tx;
   logic        init_mode, sleep_mode, irq;
   logic [1:0]  tx_req, tx_done, tx_ok;
   cfs_rx_chk_t rx_chk;
   cfs_rx_msg_t rx_msg;
   int          miscompares = 0;
   int          n_tests = 0;
   always #50 i_clock = ~i_clock;
   cfs_node_model node (.i_clock(i_clock), .o_can_rx(can_rx),
      .o_bit_tick(bit_tick), .o_rx_chk(rx_chk), .o_rx_msg(rx_msg));
   cfs_top dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_can_rx(can_rx), .i_bit_tick(bit_tick),
      .i_rx_chk(rx_chk), .i_rx_msg(rx_msg), .i_sof_detect(sof),
      .i_role_rx(role_rx), .i_role_tx(role_tx), .i_err_set(err_set),
      .i_tx_req(tx_req), .i_tx_done(tx_done), .i_tx_ok(tx_ok),
      .o_init_mode(init_mode), .o_sleep_mode(sleep_mode), .o_irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge i_clock);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      q = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      logic [31:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      chk(q & m, e);
   endtask
   task automatic ci(input logic e);
      @(negedge i_clock);
      chk({31'h0000_0000, irq}, {31'h0000_0000, e});
   endtask
   task automatic cm(input logic [1:0] e);
      @(negedge i_clock);
      chk({30'h0000_0000, init_mode, sleep_mode}, {30'h0000_0000, e});
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #200_000;
      miscompares++;
      results();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sof, role_rx, role_tx, err_set, tx_req, tx_done, tx_ok} = '0;
      repeat (8) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rc(CFS_OFS_MSTAT, 32'h0000_0002);
      rc(CFS_OFS_TSTAT, 32'h0000_0000);
      wr(CFS_OFS_MSTAT, 32'h0000_00FF);
      rc(CFS_OFS_MSTAT, 32'h0000_0002);
      rc(8'h3C, 32'h0000_0000);
      chk({31'h0000_0000, last_err}, 32'h0000_0001);
      cm(2'h1);
      $display("test reset done");
      wr(CFS_OFS_MCTRL, 32'h0000_0001);
      rc(CFS_OFS_MSTAT, 32'h0000_0001);
      cm(2'h2);
      wr(CFS_OFS_MCTRL, 32'h0000_0000);
      rc(CFS_OFS_MSTAT, 32'h0000_0001);
      repeat (24) @(posedge i_clock);
      node.dominant(8);
      repeat (20) @(posedge i_clock);
      rc(CFS_OFS_MSTAT, 32'h0000_0001);
      repeat (60) @(posedge i_clock);
      rc(CFS_OFS_MSTAT, 32'h0000_0000);
      cm(2'h0);
      $display("test init done");
      node.send(64'h0000_0000_0000_0001, 1'b0, 1'b1);
      node.send(64'h0000_0000_0000_0002, 1'b1, 1'b0);
      rc(CFS_OFS_FIFO, 32'h0000_0000);
      for (int i = 1; i <= 4; i++) node.send(64'hA0 + i, 1'b1, 1'b1);
      rc(CFS_OFS_FIFO, 32'h0000_000B);
      rc(CFS_OFS_MB_DLO, 32'h0000_00A1);
      wr(CFS_OFS_FIFO, 32'h0000_0020);
      rc(CFS_OFS_MB_DLO, 32'h0000_00A2);
      rc(CFS_OFS_FIFO, 32'h0000_0002);
      $display("test receive done");
      role_rx <= 1'b1;
      rc(CFS_OFS_MSTAT, 32'h0000_0020);
      role_rx <= 1'b0;
      role_tx <= 1'b1;
      rc(CFS_OFS_MSTAT, 32'h0000_0010);
      role_tx <= 1'b0;
      wr(CFS_OFS_EIER, 32'h0000_0001);
      wr(CFS_OFS_IER, 32'h0000_0000);
      err_set <= 8'h01;
      @(posedge i_clock);
      err_set <= 8'h00;
      rc(CFS_OFS_MSTAT, 32'h0000_0004);
      ci(1'b0);
      wr(CFS_OFS_IER, 32'h0000_0010);
      ci(1'b1);
      wr(CFS_OFS_ISTAT, 32'h0000_0010);
      ci(1'b0);
      wr(CFS_OFS_MSTAT, 32'h0000_0004);
      rc(CFS_OFS_MSTAT, 32'h0000_0000);
      $display("test roles and error done");
      tx_done <= 2'b10;
      tx_ok   <= 2'b10;
      @(posedge i_clock);
      tx_done <= 2'b00;
      rc(CFS_OFS_TSTAT, 32'h0000_0022);
      wr(CFS_OFS_TSTAT, 32'h0000_0002);
      rc(CFS_OFS_TSTAT, 32'h0000_0000);
      tx_done <= 2'b11;
      tx_ok   <= 2'b11;
      @(posedge i_clock);
      tx_done <= 2'b00;
      rc(CFS_OFS_TSTAT, 32'h0000_0033);
      tx_req <= 2'b10;
      @(posedge i_clock);
      tx_req <= 2'b01;
      @(posedge i_clock);
      tx_req <= 2'b00;
      rc(CFS_OFS_TSTAT, 32'h0000_0003);
      wr(CFS_OFS_TSTAT, 32'h0000_00FF);
      rc(CFS_OFS_TSTAT, 32'h0000_0000);
      $display("test transmit done");
      wr(CFS_OFS_MCTRL, 32'h0000_0002);
      rc(CFS_OFS_MSTAT, 32'h0000_0002);
      cm(2'h1);
      sof <= 1'b1;
      @(posedge i_clock);
      sof <= 1'b0;
      rc(CFS_OFS_MSTAT, 32'h0000_000A);
      wr(CFS_OFS_IER, 32'h0000_0020);
      ci(1'b1);
      wr(CFS_OFS_MCTRL, 32'h0000_0000);
      rc(CFS_OFS_MSTAT, 32'h0000_0008, 32'h0000_000A);
      wr(CFS_OFS_MCTRL, 32'h0000_0022);
      @(posedge i_clock);
      sof <= 1'b1;
      @(posedge i_clock);
      sof <= 1'b0;
      rc(CFS_OFS_MCTRL, 32'h0000_0020);
      rc(CFS_OFS_MSTAT, 32'h0000_0000, 32'h0000_0002);
      $display("test sleep done");
      results();
   end
endmodule
